/* hdl/pci_ctl_pkg.sv */
// constants shared by the pci control-signal block and its parity unit
// assumes one pci clock domain and a synchronous active-low reset
package pci_ctl_pkg;

  // configuration command register, byte address and field positions
  localparam logic [7:0] CMD_REG_OFS = 8'h04;
  localparam int CMD_W = 16;
  localparam int CMD_MEM_EN = 1;
  localparam int CMD_MASTER_EN = 2;
  localparam int CMD_PERR_EN = 6;
  localparam int CMD_SERR_EN = 8;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] CMD_WMASK = 16'h0146; // writable bits only

  // bus command encodings as seen on the command/byte-enable lines
  localparam logic [2:0] CFG_CMD_HI = 3'h5; // config read 0xa, write 0xb
  localparam logic [1:0] CFG_TYPE0 = 2'h0;

  // initiator decode window: clocks after the address phase without devsel before master abort
  localparam int DEVSEL_TIMEOUT_CLKS = 5;

  // bus widths
  localparam int AD_W = 32;
  localparam int CBE_W = 4;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_M_ADDR,
    ST_M_DATA,
    ST_M_TURN,
    ST_T_DATA,
    ST_T_TURN
  } bus_state_t;

endpackage : pci_ctl_pkg

/* hdl/par_link_if.sv */
// carrier between the control block and its parity unit
// assumes both ends share the pci clock
`timescale 1ns/1ns
interface par_link_if;
  import pci_ctl_pkg::*;
  logic [AD_W-1:0] ad;
  logic [CBE_W-1:0] cbe_b;
  logic par_in;
  logic chk_data;
  logic chk_addr;
  logic par_gen;
  logic data_err;
  logic addr_err;

  modport ctl (output ad, cbe_b, par_in, chk_data, chk_addr,
               input par_gen, data_err, addr_err);
  modport par (input ad, cbe_b, par_in, chk_data, chk_addr,
               output par_gen, data_err, addr_err);
endinterface : par_link_if

/* hdl/pci_parity_unit.sv */
// even-parity generator and checker for the address/data bus
// assumes bus pins are sampled synchronously to the pci clock
`timescale 1ns/1ns
module pci_parity_unit
  import pci_ctl_pkg::*;
#(
  parameter int W_AD = AD_W,
  parameter int W_CBE = CBE_W
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  par_link_if.par pl
);

  typedef struct packed {
    logic par;
    logic chk_d;
    logic chk_a;
    logic data_err;
    logic addr_err;
  } par_st_t;

  par_st_t q, d;

  // parity of this cycle is driven or compared one clock later
  always_comb begin
    d = q;
    d.par = ^{pl.ad[W_AD-1:0], pl.cbe_b[W_CBE-1:0]};
    d.chk_d = pl.chk_data;
    d.chk_a = pl.chk_addr;
    d.data_err = q.chk_d & (pl.par_in != q.par);
    d.addr_err = q.chk_a & (pl.par_in != q.par);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pl.par_gen = q.par;
  assign pl.data_err = q.data_err;
  assign pl.addr_err = q.addr_err;

endmodule : pci_parity_unit

/* hdl/pci_bus_ctl.sv */
// pci control-signal block: target claim, initiator sequencing, errors
// assumes the address/data path lies outside; all pins are synchronous
// Function
// - claim a decoded cycle by asserting device select
// - as initiator, end unclaimed cycles with a master abort
// - initiator drives frame, held while more data follows
// - frame deasserted marks the final data phase
// - start as initiator only when granted and the bus is idle
// - answer configuration cycles only while idsel is high
// - a data phase completes when irdy and trdy sampled asserted
// - otherwise each clock is a wait state
// - initiator asserts irdy only when able to finish the phase
// - target asserts trdy only when able to finish the phase
// - drive perr on parity mismatch only if command bit 6 set
// - pulse serr only if command bit 8 set
// - serr may fire while not the target of the cycle
// - serr also pulses for a socket address parity error
// - target stop makes the initiator end the transaction
// - assert request while initiator ownership is needed
// - even parity on par one clock after the covered phase
// - command lines carry command, then per-lane byte enables
`timescale 1ns/1ns
module pci_bus_ctl
  import pci_ctl_pkg::*;
#(
  parameter int LEN_W = 4,
  parameter int TMO_CLKS = DEVSEL_TIMEOUT_CLKS
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic [AD_W-1:0] I_AD,
  input wire logic [CBE_W-1:0] I_CBE_B,
  input wire logic I_PAR,
  input wire logic I_FRAME_B,
  input wire logic I_IRDY_B,
  input wire logic I_TRDY_B,
  input wire logic I_DEVSEL_B,
  input wire logic I_STOP_B,
  input wire logic I_GNT_B,
  input wire logic I_IDSEL,
  input wire logic I_MST_REQ,
  input wire logic I_MST_WR,
  input wire logic [LEN_W-1:0] I_MST_LEN,
  input wire logic I_MST_RDY,
  input wire logic I_TGT_HIT,
  input wire logic I_TGT_RDY,
  input wire logic I_TGT_DISC,
  input wire logic I_SYS_ERR,
  input wire logic I_CB_ADDR_PERR,
  output logic [AD_W-1:0] O_AD,
  output logic O_AD_OE_B,
  output logic O_PAR,
  output logic O_PAR_OE_B,
  output logic O_FRAME_B,
  output logic O_FRAME_OE_B,
  output logic O_IRDY_B,
  output logic O_IRDY_OE_B,
  output logic O_TRDY_B,
  output logic O_DEVSEL_B,
  output logic O_STOP_B,
  output logic O_TGT_OE_B,
  output logic O_PERR_B,
  output logic O_PERR_OE_B,
  output logic O_SERR_B,
  output logic O_SERR_OE_B,
  output logic O_REQ_B,
  output logic [CMD_W-1:0] O_CMD,
  output logic O_MST_XFER,
  output logic O_MST_DONE,
  output logic O_MST_ABORT,
  output logic O_MST_STOPPED,
  output logic O_TGT_XFER
);

  localparam int TW = $clog2(TMO_CLKS + 1);

  // refuse parameters the sequencing cannot serve
  if (LEN_W < 1 || TMO_CLKS < 2) begin : g_bad_param
    $error("pci_bus_ctl: LEN_W must be >= 1 and TMO_CLKS >= 2");
  end

  typedef struct packed {
    bus_state_t state;
    logic [LEN_W-1:0] left;
    logic [TW-1:0] tmo;
    logic seen;
    logic abt;
    logic mst_wr;
    logic stopped;
    logic frame_prev_b;
    logic cfg;
    logic wr;
    logic sel;
    logic [CMD_W-1:0] cmd;
    logic [AD_W-1:0] ad;
    logic ad_oe_b;
    logic par_oe_b;
    logic frame_b;
    logic frame_oe_b;
    logic irdy_b;
    logic irdy_oe_b;
    logic trdy_b;
    logic devsel_b;
    logic stop_b;
    logic tgt_oe_b;
    logic perr_b;
    logic perr_oe_b;
    logic serr_b;
    logic req_b;
    logic mst_xfer;
    logic mst_done;
    logic mst_abort;
    logic tgt_xfer;
  } ctl_st_t;

  ctl_st_t q, d;
  par_link_if pl ();

  // sampled bus levels, asserted-high for readability
  logic frame;
  logic irdy;
  logic trdy;
  logic devsel;
  logic stop;
  logic complete;
  logic addr_phase;
  logic cfg_hit;
  logic mem_hit;
  logic perr_now;
  logic [LEN_W-1:0] left_dec;

  assign frame = !I_FRAME_B;
  assign irdy = !I_IRDY_B;
  assign trdy = !I_TRDY_B;
  assign devsel = !I_DEVSEL_B;
  assign stop = !I_STOP_B;
  assign complete = irdy & trdy;
  assign addr_phase = frame & q.frame_prev_b;
  assign cfg_hit = I_IDSEL && I_CBE_B[3:1] == CFG_CMD_HI
                   && I_AD[1:0] == CFG_TYPE0;
  assign mem_hit = I_TGT_HIT & q.cmd[CMD_MEM_EN];
  assign perr_now = pl.data_err & q.cmd[CMD_PERR_EN];
  assign left_dec = q.left - LEN_W'(1);

  // parity unit sees raw pins; checks run for received phases only
  assign pl.ad = I_AD;
  assign pl.cbe_b = I_CBE_B;
  assign pl.par_in = I_PAR;
  assign pl.chk_addr = addr_phase && q.state == ST_IDLE;
  assign pl.chk_data = complete && ((q.state == ST_T_DATA && q.wr
                       && !q.trdy_b) || (q.state == ST_M_DATA
                       && !q.mst_wr));

  pci_parity_unit #(
    .W_AD(AD_W),
    .W_CBE(CBE_W)
  ) u_parity (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .pl(pl.par)
  );

  // next-state logic for both initiator and target roles
  always_comb begin
    d = q;
    d.frame_prev_b = I_FRAME_B;
    d.mst_xfer = 1'b0;
    d.mst_done = 1'b0;
    d.mst_abort = 1'b0;
    d.tgt_xfer = 1'b0;
    // par follows every phase this block drove on the bus
    d.par_oe_b = !(q.state == ST_M_ADDR
                   || (q.state == ST_M_DATA && q.mst_wr)
                   || !q.ad_oe_b);
    // perr held one extra clock deasserted before release
    d.perr_b = !perr_now;
    d.perr_oe_b = !(perr_now || !q.perr_b);
    // serr fires regardless of whether this device is the target
    d.serr_b = !(q.cmd[CMD_SERR_EN] && (I_SYS_ERR
                 || I_CB_ADDR_PERR
                 || (pl.addr_err && q.cmd[CMD_PERR_EN])));
    unique case (q.state)
      ST_IDLE: begin
        d.req_b = !(I_MST_REQ && q.cmd[CMD_MASTER_EN]);
        if (!q.req_b && !I_GNT_B && !frame && !irdy) begin
          d.state = ST_M_ADDR;
          d.req_b = 1'b1;
          d.frame_b = 1'b0;
          d.frame_oe_b = 1'b0;
          d.irdy_b = 1'b1;
          d.irdy_oe_b = 1'b0;
          d.left = I_MST_LEN;
          d.mst_wr = I_MST_WR;
          d.tmo = '0;
          d.seen = 1'b0;
          d.abt = 1'b0;
          d.stopped = 1'b0;
        end else if (addr_phase && (cfg_hit || mem_hit)) begin
          d.state = ST_T_DATA;
          d.devsel_b = 1'b0;
          d.trdy_b = 1'b1;
          d.stop_b = 1'b1;
          d.tgt_oe_b = 1'b0;
          d.ad_oe_b = 1'b1; // turnaround clock before read data
          d.cfg = cfg_hit;
          d.wr = I_CBE_B[0];
          d.sel = I_AD[7:2] == CMD_REG_OFS[7:2];
        end
      end
      ST_M_ADDR: begin
        d.state = ST_M_DATA;
        d.tmo = TW'(1);
        d.irdy_b = !I_MST_RDY;
        d.frame_b = (q.left <= LEN_W'(1)) && I_MST_RDY;
      end
      ST_M_DATA: begin
        d.seen = q.seen | devsel;
        if (!d.seen) begin
          d.tmo = q.tmo + TW'(1);
        end
        if (q.abt) begin
          d.state = ST_M_TURN;
          d.irdy_b = 1'b1;
          d.mst_done = 1'b1;
          d.mst_abort = 1'b1;
        end else if (!d.seen && q.tmo == TW'(TMO_CLKS)) begin
          // frame dropped and irdy asserted in the same clock, as an abort demands
          d.abt = 1'b1;
          d.frame_b = 1'b1;
          d.irdy_b = 1'b0;
        end else if (q.frame_b && irdy && (trdy || stop)) begin
          d.state = ST_M_TURN;
          d.irdy_b = 1'b1;
          d.mst_xfer = trdy;
          d.mst_done = 1'b1;
          d.stopped = q.stopped | stop;
        end else if (complete) begin
          d.mst_xfer = 1'b1;
          d.left = left_dec;
          d.irdy_b = !I_MST_RDY;
          d.frame_b = (left_dec <= LEN_W'(1)) && I_MST_RDY;
        end else if (stop && !q.frame_b) begin
          // disconnect: drop frame now, finish on the next phase
          d.stopped = 1'b1;
          d.frame_b = 1'b1;
          d.irdy_b = q.irdy_b && !I_MST_RDY;
        end else if (q.irdy_b) begin
          d.irdy_b = !I_MST_RDY;
          if (!q.frame_b) begin
            d.frame_b = (q.left <= LEN_W'(1)) && I_MST_RDY;
          end
        end
      end
      ST_M_TURN: begin
        // one clock driven high, then released to the pullups
        d.state = ST_IDLE;
        d.frame_oe_b = 1'b1;
        d.irdy_oe_b = 1'b1;
      end
      ST_T_DATA: begin
        d.ad = (q.cfg && q.sel) ? AD_W'(q.cmd) : '0;
        d.ad_oe_b = q.wr;
        if (q.trdy_b) begin
          // once asserted, trdy holds until the phase completes
          d.trdy_b = !(q.cfg || I_TGT_RDY);
          d.stop_b = !(q.cfg || I_TGT_DISC);
          if (!q.wr && q.ad_oe_b) begin
            d.trdy_b = 1'b1;
            d.stop_b = 1'b1;
          end
        end
        if (complete && !q.trdy_b) begin
          d.tgt_xfer = 1'b1;
          if (q.cfg && q.wr && q.sel) begin
            for (int b = 0; b < CMD_W / 8; b++) begin
              if (!I_CBE_B[b]) begin
                d.cmd[b*8 +: 8] = I_AD[b*8 +: 8] & CMD_WMASK[b*8 +: 8];
              end
            end
          end
          d.trdy_b = !(q.cfg || I_TGT_RDY);
        end
        if ((irdy && !frame && (!q.trdy_b || !q.stop_b))
            || (complete && !q.trdy_b && !frame)) begin
          d.state = ST_T_TURN;
          d.devsel_b = 1'b1;
          d.trdy_b = 1'b1;
          d.stop_b = 1'b1;
          d.ad_oe_b = 1'b1;
        end else if (!q.stop_b) begin
          // a stop once shown holds until the transaction ends
          d.stop_b = 1'b0;
        end
      end
      ST_T_TURN: begin
        d.state = ST_IDLE;
        d.tgt_oe_b = 1'b1;
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
  end

  // single register stage holds the block state; parity state sits in u_parity
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) begin
      q <= '0;
      q.state <= ST_IDLE;
      q.cmd <= CMD_RESET;
      q.frame_prev_b <= 1'b1;
      q.ad_oe_b <= 1'b1;
      q.par_oe_b <= 1'b1;
      q.frame_b <= 1'b1;
      q.frame_oe_b <= 1'b1;
      q.irdy_b <= 1'b1;
      q.irdy_oe_b <= 1'b1;
      q.trdy_b <= 1'b1;
      q.devsel_b <= 1'b1;
      q.stop_b <= 1'b1;
      q.tgt_oe_b <= 1'b1;
      q.perr_b <= 1'b1;
      q.perr_oe_b <= 1'b1;
      q.serr_b <= 1'b1;
      q.req_b <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // pins and user outputs straight from the state register, par from the parity unit
  assign O_AD = q.ad;
  assign O_AD_OE_B = q.ad_oe_b;
  assign O_PAR = pl.par_gen;
  assign O_PAR_OE_B = q.par_oe_b;
  assign O_FRAME_B = q.frame_b;
  assign O_FRAME_OE_B = q.frame_oe_b;
  assign O_IRDY_B = q.irdy_b;
  assign O_IRDY_OE_B = q.irdy_oe_b;
  assign O_TRDY_B = q.trdy_b;
  assign O_DEVSEL_B = q.devsel_b;
  assign O_STOP_B = q.stop_b;
  assign O_TGT_OE_B = q.tgt_oe_b;
  assign O_PERR_B = q.perr_b;
  assign O_PERR_OE_B = q.perr_oe_b;
  assign O_SERR_B = q.serr_b; // open drain: low only while pulsing
  assign O_SERR_OE_B = q.serr_b;
  assign O_REQ_B = q.req_b;
  assign O_CMD = q.cmd;
  assign O_MST_XFER = q.mst_xfer;
  assign O_MST_DONE = q.mst_done;
  assign O_MST_ABORT = q.mst_abort;
  assign O_MST_STOPPED = q.stopped;
  assign O_TGT_XFER = q.tgt_xfer;

endmodule : pci_bus_ctl

/* dv/pci_bus_ctl_props.sv */
// concurrent checks on the pins of the pci control-signal block
// assumes one pci clock domain; attached by bind from the bench
`timescale 1ns/1ns
module pci_bus_ctl_props
  import pci_ctl_pkg::*;
#(
  parameter int TMO_CLKS = DEVSEL_TIMEOUT_CLKS
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic [AD_W-1:0] I_AD,
  input wire logic [CBE_W-1:0] I_CBE_B,
  input wire logic I_FRAME_B,
  input wire logic I_IRDY_B,
  input wire logic I_TRDY_B,
  input wire logic I_DEVSEL_B,
  input wire logic I_GNT_B,
  input wire logic I_IDSEL,
  input wire logic I_MST_REQ,
  input wire logic I_SYS_ERR,
  input wire logic I_CB_ADDR_PERR,
  input wire logic O_PAR,
  input wire logic O_PAR_OE_B,
  input wire logic O_DEVSEL_B,
  input wire logic O_TGT_OE_B,
  input wire logic O_PERR_B,
  input wire logic O_PERR_OE_B,
  input wire logic O_SERR_B,
  input wire logic O_REQ_B,
  input wire logic [CMD_W-1:0] O_CMD,
  input wire logic O_FRAME_OE_B,
  input wire logic O_MST_XFER,
  input wire logic O_MST_DONE,
  input wire logic O_MST_ABORT
);
  logic [3:0] nodev_q;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_B);
  // unanswered clocks since own frame start; zeroed by any select
  always_ff @(posedge I_CLOCK) begin
    if (!I_RST_B) nodev_q <= 4'h0;
    else if ($fell(O_FRAME_OE_B)) nodev_q <= {3'h0, I_DEVSEL_B};
    else if (nodev_q != 4'h0 && I_DEVSEL_B) nodev_q <= nodev_q + 4'h1;
    else nodev_q <= 4'h0;
  end
  // type-0 config address phase seen while the block is idle
  sequence cfg_addr_s;
    $fell(I_FRAME_B) && I_IDSEL && I_CBE_B[3:1] == CFG_CMD_HI &&
      I_AD[1:0] == CFG_TYPE0 && O_FRAME_OE_B && O_TGT_OE_B;
  endsequence
  sequence serr_pulse_s;
    !O_SERR_B ##1 O_SERR_B;
  endsequence
  claim_cfg_a: assert property (cfg_addr_s |=>
    !O_DEVSEL_B && !O_TGT_OE_B) else $error("config cycle not claimed");
  start_grant_a: assert property ($fell(O_FRAME_OE_B) |->
    !$past(I_GNT_B) && $past(I_FRAME_B) && $past(I_IRDY_B))
    else $error("initiator start without grant or idle bus");
  req_need_a: assert property ($rose(I_MST_REQ) &&
    O_CMD[CMD_MASTER_EN] && O_FRAME_OE_B |=> !O_REQ_B)
    else $error("request not raised");
  nodev_abort_a: assert property (
    nodev_q == 4'(TMO_CLKS + 1) |=> O_MST_ABORT && O_MST_DONE)
    else $error("missing master abort");
  xfer_cause_a: assert property (O_MST_XFER |->
    !$past(I_IRDY_B) && !$past(I_TRDY_B)) else $error("bad transfer");
  last_phase_a: assert property (O_MST_DONE && !O_MST_ABORT |->
    $past(I_FRAME_B) && !$past(I_IRDY_B)) else $error("bad final phase");
  perr_gate_a: assert property (!O_PERR_OE_B && !O_PERR_B |->
    O_CMD[CMD_PERR_EN]) else $error("parity error while disabled");
  serr_gate_a: assert property ((I_SYS_ERR || I_CB_ADDR_PERR) &&
    O_CMD[CMD_SERR_EN] |=> serr_pulse_s)
    else $error("system error pulse wrong");
  par_even_a: assert property (!O_PAR_OE_B |->
    O_PAR == ^{$past(I_AD), $past(I_CBE_B)})
    else $error("driven parity not even over previous phase");
endmodule : pci_bus_ctl_props

/* dv/pci_far_target.sv */
// far-side target model answering the block's own initiator cycles
// assumes the bench pulls released control lines high
`timescale 1ns/1ns
module pci_far_target (
  input wire logic i_clk,
  input wire logic i_frame_b,
  input wire logic i_irdy_b,
  input wire logic [1:0] i_mode,
  output logic o_devsel_b,
  output logic o_trdy_b,
  output logic o_stop_b,
  output logic o_oe_b
);
  logic act_q = 1'b0;
  logic frame_q = 1'b1;
  initial begin
    {o_devsel_b, o_trdy_b, o_stop_b, o_oe_b} = 4'hf;
  end
  // mode 0 never claims, 1 prompt, 2 a clock slower, 3 disconnects
  always @(posedge i_clk) begin
    frame_q <= i_frame_b;
    if (!act_q) begin
      // drive from the claim, one turnaround clock after the end, then release
      o_oe_b <= !(frame_q && !i_frame_b && i_mode != 2'h0);
      if (frame_q && !i_frame_b && i_mode != 2'h0) begin
        act_q <= 1'b1;
        o_devsel_b <= i_mode == 2'h2;
      end
    end else if (i_frame_b && !i_irdy_b && !(o_trdy_b && o_stop_b)) begin
      act_q <= 1'b0;
      {o_devsel_b, o_trdy_b, o_stop_b} <= 3'h7;
    end else begin
      o_devsel_b <= 1'b0;
      o_trdy_b <= o_devsel_b | (i_mode == 2'h3);
      o_stop_b <= o_devsel_b | (i_mode != 2'h3);
    end
  end
endmodule : pci_far_target

/* dv/pci_bus_ctl_test.sv */
// self-checking bench: config cycles, initiator runs, error pins
// assumes pull-ups on released control lines and a parked arbiter
`timescale 1ns/1ns
module pci_bus_ctl_test;
  import pci_ctl_pkg::*;
  logic I_CLOCK = 1'b0;
  logic I_RST_B, I_PAR, I_GNT_B, I_IDSEL, I_MST_REQ, I_MST_WR, I_MST_RDY;
  logic [AD_W-1:0] I_AD, O_AD, tb_ad;
  logic [CBE_W-1:0] I_CBE_B;
  logic [3:0] I_MST_LEN;
  logic [CMD_W-1:0] O_CMD;
  logic I_FRAME_B, I_IRDY_B, I_TRDY_B, I_DEVSEL_B, I_STOP_B;
  logic I_TGT_HIT, I_TGT_RDY, I_TGT_DISC, I_SYS_ERR, I_CB_ADDR_PERR;
  logic O_AD_OE_B, O_PAR, O_PAR_OE_B, O_FRAME_B, O_FRAME_OE_B, O_IRDY_B;
  logic O_IRDY_OE_B, O_TRDY_B, O_DEVSEL_B, O_STOP_B, O_TGT_OE_B, O_PERR_B;
  logic O_PERR_OE_B, O_SERR_B, O_SERR_OE_B, O_REQ_B, O_MST_XFER;
  logic O_MST_DONE, O_MST_ABORT, O_MST_STOPPED, O_TGT_XFER;
  logic tb_frame_b, tb_irdy_b, tb_par, tb_bad, p_dev_b, p_trdy_b, p_stop_b;
  logic p_oe_b;
  logic [1:0] mode;
  logic [31:0] rd, cmd;
  int seed, err_total, tests_run, k;
  int perr_n = 0;
  int serr_n = 0;
  int tgt_n = 0;
  int stop_n = 0;
  // wire levels: the driving party wins, released lines float high
  assign I_FRAME_B = O_FRAME_OE_B ? tb_frame_b : O_FRAME_B;
  assign I_IRDY_B = O_IRDY_OE_B ? tb_irdy_b : O_IRDY_B;
  assign I_DEVSEL_B = O_TGT_OE_B ? (p_oe_b | p_dev_b) : O_DEVSEL_B;
  assign I_TRDY_B = O_TGT_OE_B ? (p_oe_b | p_trdy_b) : O_TRDY_B;
  assign I_STOP_B = O_TGT_OE_B ? (p_oe_b | p_stop_b) : O_STOP_B;
  assign I_AD = O_AD_OE_B ? tb_ad : O_AD;
  assign I_PAR = O_PAR_OE_B ? tb_par : O_PAR;
  always #50 I_CLOCK = ~I_CLOCK;
  // bench parity, parked arbiter, error pulse counters
  always @(posedge I_CLOCK) begin
    tb_par <= ^{I_AD, I_CBE_B} ^ tb_bad;
    I_GNT_B <= O_REQ_B;
    if (O_PERR_OE_B === 1'b0 && O_PERR_B === 1'b0) perr_n <= perr_n + 1;
    if (O_SERR_B === 1'b0) serr_n <= serr_n + 1;
    if (O_TGT_XFER === 1'b1) tgt_n <= tgt_n + 1;
    if (O_TGT_OE_B === 1'b0 && O_STOP_B === 1'b0) stop_n <= stop_n + 1;
  end
  pci_bus_ctl #(.LEN_W(4), .TMO_CLKS(DEVSEL_TIMEOUT_CLKS)) DUT (
    .I_CLOCK, .I_RST_B, .I_AD, .I_CBE_B, .I_PAR, .I_FRAME_B, .I_IRDY_B,
    .I_TRDY_B, .I_DEVSEL_B, .I_STOP_B, .I_GNT_B, .I_IDSEL, .I_MST_REQ,
    .I_MST_WR, .I_MST_LEN, .I_MST_RDY, .I_TGT_HIT, .I_TGT_RDY, .I_TGT_DISC,
    .I_SYS_ERR, .I_CB_ADDR_PERR, .O_AD, .O_AD_OE_B, .O_PAR, .O_PAR_OE_B,
    .O_FRAME_B, .O_FRAME_OE_B, .O_IRDY_B, .O_IRDY_OE_B, .O_TRDY_B,
    .O_DEVSEL_B, .O_STOP_B, .O_TGT_OE_B, .O_PERR_B, .O_PERR_OE_B, .O_SERR_B,
    .O_SERR_OE_B, .O_REQ_B, .O_CMD, .O_MST_XFER, .O_MST_DONE, .O_MST_ABORT,
    .O_MST_STOPPED, .O_TGT_XFER);
  pci_far_target far (.i_clk(I_CLOCK), .i_frame_b(I_FRAME_B),
    .i_irdy_b(I_IRDY_B), .i_mode(mode), .o_devsel_b(p_dev_b),
    .o_trdy_b(p_trdy_b), .o_stop_b(p_stop_b), .o_oe_b(p_oe_b));
  task automatic results();
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [31:0] exp_x(logic [1:0] m, logic [3:0] len);
    if (m == 2'h0 || m == 2'h3) return 32'h0;
    return (len == 4'h0) ? 32'h1 : {28'h0, len};
  endfunction : exp_x
  // single-phase config cycle to the command dword; read data into rd
  task automatic cfg(input logic wr, sel, bad, input logic [31:0] wd);
    int n;
    int t;
    @(posedge I_CLOCK);
    t = tgt_n;
    tb_frame_b <= 1'b0;
    tb_ad <= {24'h0, CMD_REG_OFS};
    I_CBE_B <= {CFG_CMD_HI, wr};
    I_IDSEL <= sel;
    @(posedge I_CLOCK);
    tb_frame_b <= 1'b1;
    tb_irdy_b <= 1'b0;
    {tb_ad, I_CBE_B, I_IDSEL, tb_bad} <= {wd, 4'h0, 1'b0, bad};
    n = 0;
    do begin
      @(posedge I_CLOCK);
      n++;
    end while (I_TRDY_B && n < 8);
    rd = I_AD;
    chk("cfg trdy", 32'h0, {31'h0, sel && I_TRDY_B});
    if (sel && I_TRDY_B) results();
    {tb_irdy_b, tb_bad, tb_ad} <= {2'h2, ~wd};
    repeat (4) @(posedge I_CLOCK);
    chk("tgt xfer", {31'h0, sel}, tgt_n - t);
  endtask : cfg
  // one initiator transaction against the far-side model in mode m
  task automatic mst(input logic [1:0] m, input logic [3:0] len);
    int n;
    int x;
    @(posedge I_CLOCK);
    {mode, I_MST_REQ, I_MST_LEN} <= {m, 1'b1, len};
    I_MST_WR <= 1'($random(seed));
    n = 0;
    x = 0;
    do begin
      @(posedge I_CLOCK);
      n++;
      if (O_MST_XFER === 1'b1) x++;
      I_MST_RDY <= 1'($random(seed));
    end while (O_MST_DONE !== 1'b1 && n < 300);
    chk("done", 32'h1, {31'h0, O_MST_DONE});
    if (O_MST_DONE !== 1'b1) results();
    {I_MST_REQ, mode} <= 3'h0;
    chk("xfers", exp_x(m, len), x);
    chk("abort", {31'h0, m == 2'h0}, {31'h0, O_MST_ABORT});
    chk("stopped", {31'h0, m == 2'h3}, {31'h0, O_MST_STOPPED});
    repeat (3) @(posedge I_CLOCK);
  endtask : mst
  initial begin
    seed = 55;
    {err_total, tests_run} = 64'h0;
    {I_RST_B, I_IDSEL, I_MST_REQ, I_MST_WR, I_MST_RDY} = 5'h1;
    {I_TGT_HIT, I_TGT_RDY, I_TGT_DISC, I_SYS_ERR, I_CB_ADDR_PERR} = 5'h0;
    {tb_frame_b, tb_irdy_b, tb_bad, mode} = 5'h18;
    {tb_ad, I_CBE_B, I_MST_LEN} = {32'h0, 4'hf, 4'h1};
    repeat (6) @(posedge I_CLOCK);
    I_RST_B <= 1'b1;
    @(posedge I_CLOCK);
    chk("cmd reset", {16'h0, CMD_RESET}, {16'h0, O_CMD});
    cfg(1'b1, 1'b1, 1'b0, 32'hffff_ffff);
    cfg(1'b0, 1'b1, 1'b0, 32'h0);
    chk("cmd mask", {16'h0, CMD_WMASK}, rd);
    cfg(1'b1, 1'b0, 1'b0, 32'h0);
    cfg(1'b0, 1'b1, 1'b0, 32'h0);
    chk("no idsel", {16'h0, CMD_WMASK}, rd);
    // decoded memory claim with disconnect: one stop, no data phase
    k = stop_n;
    {I_TGT_HIT, I_TGT_DISC} <= 2'h3;
    cfg(1'b1, 1'b0, 1'b0, 32'h0);
    {I_TGT_HIT, I_TGT_DISC} <= 2'h0;
    chk("stop", 32'h1, stop_n - k);
    // error pins stay quiet while disabled and pulse once when enabled
    for (int e = 0; e < 2; e++) begin
      cmd = (e == 1) ? 32'h0146 : 32'h0006;
      cfg(1'b1, 1'b1, 1'b0, cmd);
      k = perr_n;
      cfg(1'b1, 1'b1, 1'b1, cmd);
      chk("perr", e, perr_n != k);
      for (int s = 0; s < 2; s++) begin
        k = serr_n;
        @(posedge I_CLOCK);
        {I_SYS_ERR, I_CB_ADDR_PERR} <= (s == 1) ? 2'h2 : 2'h1;
        @(posedge I_CLOCK);
        {I_SYS_ERR, I_CB_ADDR_PERR} <= 2'h0;
        repeat (3) @(posedge I_CLOCK);
        chk("serr", e, serr_n - k);
      end
    end
    mst(2'h0, 4'h1);
    mst(2'h3, 4'h2);
    mst(2'h1, 4'h0);
    for (int i = 0; i < 12; i++) begin
      mst(2'($random(seed)), 4'($random(seed)));
    end
    results();
  end
endmodule : pci_bus_ctl_test
bind pci_bus_ctl pci_bus_ctl_props #(.TMO_CLKS(TMO_CLKS)) props (
  .I_CLOCK, .I_RST_B, .I_AD, .I_CBE_B, .I_FRAME_B, .I_IRDY_B, .I_TRDY_B,
  .I_DEVSEL_B, .I_GNT_B, .I_IDSEL, .I_MST_REQ, .I_SYS_ERR, .I_CB_ADDR_PERR,
  .O_PAR, .O_PAR_OE_B,
  .O_DEVSEL_B, .O_TGT_OE_B, .O_PERR_B, .O_PERR_OE_B, .O_SERR_B, .O_REQ_B,
  .O_CMD, .O_FRAME_OE_B, .O_MST_XFER, .O_MST_DONE, .O_MST_ABORT);
